// ===== dsk_defines.svh
// Timing and field constants for the disk seek and write start interface.
// Assumes a 100 MHz system clock and a 5.75 MHz adapter clock made as an enable.
`ifndef DSK_DEFINES_SVH
`define DSK_DEFINES_SVH
`define DSK_SYS_CLK_KHZ 100000
`define DSK_ADP_CLK_KHZ 5750
// Adapter tick spacing in system clocks; 100/5.75 is about 17.4, rounded to 17.
`define DSK_ADP_DIV ((`DSK_SYS_CLK_KHZ + `DSK_ADP_CLK_KHZ / 2) / `DSK_ADP_CLK_KHZ)
// One-shot widths in microseconds, then in adapter ticks rounded to nearest.
`define DSK_SETUP_US 2
`define DSK_TAG_US 2
`define DSK_SECT_US 2
`define DSK_TAS_US 80
`define DSK_MATCH_US 70
`define DSK_RDLY_US 60
`define DSK_PRE_US 130
`define DSK_TICKS(us) (((us) * `DSK_ADP_CLK_KHZ + 500) / 1000)
// Command codes on the two command lines, as {bit_b, bit_a}.
`define DSK_CMD_READ 2'h0
`define DSK_CMD_WRITE 2'h1
`define DSK_CMD_SEEK 2'h2
`define DSK_CMD_RECALIBRATE_COMMAND 2'h3
`define DSK_CNT_W 12
`endif

// ===== dsk_drive_model.sv
// Drive side model: acknowledge, attention and a rotating sector stream.
// Assumes the bench chooses whether the drive answers a seek at all.
`timescale 1ns/1ps
`default_nettype none
module dsk_drive_model #(
    parameter int PERIOD = 13500
)(
    input wire logic i_sys_clk,
    input wire logic i_strobe_n,
    input wire logic [3:0] i_select,
    input wire logic i_ack_on,
    output logic o_ack_n,
    output logic [3:0] o_attention,
    output logic o_sector_mark,
    output logic [3:0] o_sector
);
    initial
    begin
        o_ack_n = 1'b1;
        o_attention = 4'h0;
        forever
        begin
            @(negedge i_strobe_n);
            o_attention <= 4'h0;
            repeat (50) @(posedge i_sys_clk);
            // The address is ignored; the model only works out that a move is done.
            if (i_ack_on)
            begin
                o_ack_n <= 1'b0;
                @(posedge i_strobe_n);
                @(posedge i_sys_clk);
                // The model drives acknowledge high again one clock after the strobe rises.
                o_ack_n <= 1'b1;
                repeat (100) @(posedge i_sys_clk);
                o_attention <= i_select;
            end
        end
    end
    initial
    begin
        o_sector_mark = 1'b0;
        o_sector = 4'h0;
        forever
        begin
            repeat (PERIOD - 8) @(posedge i_sys_clk);
            o_sector_mark <= 1'b1;
            repeat (8) @(posedge i_sys_clk);
            o_sector_mark <= 1'b0;
            o_sector <= o_sector + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== dsk_pkg.sv
// Types shared by the disk seek and write start interface.
// Assumes dsk_defines.svh supplies the numeric constants.
`default_nettype none
package dsk_pkg;
    typedef enum logic [3:0] {
        DSK_WS_10 = 4'h1,
        DSK_WS_11 = 4'h2,
        DSK_WS_01 = 4'h4,
        DSK_WS_00 = 4'h8
    } dsk_wstate_t;
endpackage
`default_nettype wire

// ===== dsk_seek_write.sv
// Seek handshake, sector match and write start timing of the disk adapter.
// Assumes controller and drive pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "dsk_defines.svh"

// Function
// RQ1: Seek logic runs only when the command lines decode to seek or recalibrate.
// RQ2: Low cylinder load fires setup delay, then tag pulse, then sets track strobe.
// RQ3: Bus bits 0 to 7 load the track address register during tag.
// RQ4: Recalibrate also loads a home-heads bit; drive then returns to track 000.
// RQ5: Set track strobe drives the active-low track address strobe.
// RQ6: Address stays put; active-low acknowledge clears the track strobe directly.
// RQ7: Strobe set starts 80 us delay; then a clear pulse ends the strobe.
// RQ8: Two-bit unit code selects exactly one of four drive units.
// RQ9: Drive attention lines one to four pass to controller lines zero to three.
// RQ10: Selected unit attention pulses seek complete toward the controller.
// RQ11: Read/write command with control strobe starts; write sets read/write flop.
// RQ12: Read/write flop releases sector match; sector addresses compared bitwise.
// RQ13: Sector pulse fires short delay; its end sets match if addresses equal.
// RQ14: Sector match clears checkword register and bit counter.
// RQ15: Match starts 70 us delay, whose end starts 60 us post match delay.
// RQ16: End of 70 us sets write enable, gating the four-state slot counter.
// RQ17: State 10 is clock slot, state 01 is data slot.
// RQ18: Write enable drives the active-low write gate.
// RQ19: Preamble lasts 130 us: zeros ending in one single one bit. Code ends it 130 us after match, 60 us after the gates turn on.
// RQ20: Preamble starts only with post match delay, stop clear and write.
// RQ21: Write and erase gates and preamble begin 70 us after sector mark.
// RQ22: After data, zeros continue until 70 us past next mark, then gates off.
// RQ23: For reads the read gate opens 130 us after the sector mark.
// RQ24: Stop flag ends the transfer and reports done to the controller.
// RQ25: Clear pulse width is a parameter; reset clears the main flops.
// RQ26: Delays are counters on the adapter clock, rounded to nearest tick.
module dsk_seek_write #(
    parameter int CLR_PULSE_TICKS = 2
)(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_command_code_bit_a,
    input wire logic i_command_code_bit_b,
    input wire logic i_cylinder_load_request_n,
    input wire logic [7:0] i_bus,
    input wire logic i_unit_code_low,
    input wire logic i_unit_code_high,
    input wire logic i_addr_ack_n,
    input wire logic [3:0] i_drive_attention,
    input wire logic i_transfer_control_strobe,
    input wire logic [3:0] i_req_sector,
    input wire logic [3:0] i_drive_sector_address,
    input wire logic i_sector_mark,
    input wire logic i_transfer_stop_flag,
    input wire logic i_write_data,
    output logic [7:0] o_track_line,
    output logic o_home_heads,
    output logic o_track_strobe_n,
    output logic [3:0] o_unit_select,
    output logic [3:0] o_controller_attention,
    output logic o_seek_complete,
    output logic o_checkword_clear,
    output logic o_post_match_delay,
    output logic o_write_gate_n,
    output logic o_erase_gate_n,
    output logic o_read_gate,
    output logic o_write_clock_data,
    output logic o_clock_bit_slot,
    output logic o_data_bit_slot,
    output logic o_done
);
    localparam int SYN = 10;
    localparam int DIV = `DSK_ADP_DIV;
    localparam int T_SETUP = `DSK_TICKS(`DSK_SETUP_US);
    localparam int T_TAG = `DSK_TICKS(`DSK_TAG_US);
    localparam int T_SECT = `DSK_TICKS(`DSK_SECT_US);
    localparam int T_TAS = `DSK_TICKS(`DSK_TAS_US);
    localparam int T_MATCH = `DSK_TICKS(`DSK_MATCH_US);
    localparam int T_RDLY = `DSK_TICKS(`DSK_RDLY_US);
    localparam int T_PRE = `DSK_TICKS(`DSK_PRE_US);

    // Two-stage synchronisers; only stage two is read by logic.
    logic [SYN-1:0] sync1_reg, sync2_reg;
    logic [SYN-1:0] raw;
    logic [7:0] bus1_reg, bus2_reg;
    logic [3:0] rsec1_reg, rsec2_reg, dsec1_reg, dsec2_reg;
    assign raw = {i_write_data, i_transfer_stop_flag, i_sector_mark,
                  i_transfer_control_strobe, i_addr_ack_n, i_cylinder_load_request_n,
                  i_unit_code_high, i_unit_code_low, i_command_code_bit_b,
                  i_command_code_bit_a};
    logic [3:0] att1_reg, att2_reg;
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            sync1_reg <= 10'h3F0 ^ 10'h3C0;
            sync2_reg <= 10'h030;
            bus1_reg <= 8'h00;
            bus2_reg <= 8'h00;
            rsec1_reg <= 4'h0;
            rsec2_reg <= 4'h0;
            dsec1_reg <= 4'h0;
            dsec2_reg <= 4'h0;
            att1_reg <= 4'h0;
            att2_reg <= 4'h0;
        end
        else
        begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
            bus1_reg <= i_bus;
            bus2_reg <= bus1_reg;
            rsec1_reg <= i_req_sector;
            rsec2_reg <= rsec1_reg;
            dsec1_reg <= i_drive_sector_address;
            dsec2_reg <= dsec1_reg;
            att1_reg <= i_drive_attention;
            att2_reg <= att1_reg;
        end
    end
    logic [1:0] cmd, unit;
    logic cyl_n, ack_n, ctl, smark, stop, wdata;
    assign cmd = {sync2_reg[1], sync2_reg[0]};
    assign unit = {sync2_reg[3], sync2_reg[2]};
    assign cyl_n = sync2_reg[4];
    assign ack_n = sync2_reg[5];
    assign ctl = sync2_reg[6];
    assign smark = sync2_reg[7];
    assign stop = sync2_reg[8];
    assign wdata = sync2_reg[9];

    logic [4:0] div_reg, div_next;
    logic tick;
    always_comb
    begin
        tick = (div_reg == 5'(DIV - 1));
        div_next = tick ? 5'h00 : div_reg + 5'h01;
    end

    // One-shot timers, all counted in adapter ticks; see RQ26.
    localparam int NT = 7;
    logic [NT-1:0] os_start, os_run, os_end;
    logic [`DSK_CNT_W-1:0] os_len [NT];
    logic [`DSK_CNT_W-1:0] os_cnt_reg [NT];
    logic [`DSK_CNT_W-1:0] os_cnt_next [NT];
    assign os_len[0] = `DSK_CNT_W'(T_SETUP);
    assign os_len[1] = `DSK_CNT_W'(T_TAG);
    assign os_len[2] = `DSK_CNT_W'(T_TAS);
    assign os_len[3] = `DSK_CNT_W'(CLR_PULSE_TICKS); // see RQ25
    assign os_len[4] = `DSK_CNT_W'(T_SECT);
    assign os_len[5] = `DSK_CNT_W'(T_MATCH);
    assign os_len[6] = `DSK_CNT_W'(T_RDLY);
    logic [`DSK_CNT_W-1:0] pre_cnt_reg, pre_cnt_next;
    genvar g;
    generate
        for (g = 0; g < NT; g++)
        begin : g_os
            assign os_run[g] = (os_cnt_reg[g] != '0);
            assign os_end[g] = tick && (os_cnt_reg[g] == `DSK_CNT_W'(1));
            always_comb
            begin
                os_cnt_next[g] = os_cnt_reg[g];
                if (os_start[g])
                    os_cnt_next[g] = os_len[g];
                else if (tick && os_run[g])
                    os_cnt_next[g] = os_cnt_reg[g] - `DSK_CNT_W'(1);
            end
            always_ff @(posedge i_sys_clk)
            begin
                if (i_reset)
                    os_cnt_reg[g] <= '0;
                else
                    os_cnt_reg[g] <= os_cnt_next[g];
            end
        end
    endgenerate

    // Control flops.
    logic tas_reg, tas_next, rw_reg, rw_next, match_reg, match_next;
    logic write_enable_flop_reg, write_enable_flop_next, rgate_reg, rgate_next, done_reg, done_next;
    logic cyl_d_reg, smark_d_reg, att_hit_reg, att_hit_next;
    logic [7:0] track_reg, track_next;
    logic home_reg, home_next, seek_cmd, rw_cmd;
    logic [3:0] ring_reg, ring_next;
    logic rd_ok, pre_end, eop_reg, eop_next, sync_reg, sync_next;
    logic den_reg, den_next, pre_ok, sel_att, out_reg, out_next;
    logic [3:0] sel_dec;

    always_comb
    begin
        seek_cmd = (cmd == `DSK_CMD_SEEK) || (cmd == `DSK_CMD_RECALIBRATE_COMMAND); // see RQ1
        rw_cmd = (cmd == `DSK_CMD_READ) || (cmd == `DSK_CMD_WRITE);
        sel_dec = 4'h1 << unit; // see RQ8
        sel_att = |(att2_reg & sel_dec);
        track_next = track_reg;
        home_next = home_reg;
        if (os_run[1])
        begin
            track_next = bus2_reg; // see RQ3
            home_next = (cmd == `DSK_CMD_RECALIBRATE_COMMAND); // see RQ4
        end
        tas_next = tas_reg;
        if (os_end[1])
            tas_next = 1'b1; // see RQ2
        if (!ack_n || os_run[3])
            tas_next = 1'b0; // see RQ6 and RQ7
        rw_next = rw_reg;
        if (ctl && rw_cmd)
            rw_next = (cmd == `DSK_CMD_WRITE); // see RQ11
        if (done_reg)
            rw_next = 1'b0;
        match_next = match_reg;
        if (os_end[4] && (rsec2_reg ^ dsec2_reg) == 4'h0)
            match_next = 1'b1; // see RQ13
        if (!rw_reg && !(ctl && rw_cmd))
            match_next = 1'b0; // see RQ12
        write_enable_flop_next = write_enable_flop_reg;
        if (os_end[5] && rw_reg && !stop)
            write_enable_flop_next = 1'b1; // see RQ16 and RQ21
        if (os_end[5] && stop)
            write_enable_flop_next = 1'b0; // see RQ22
        if (!rw_reg && !stop)
            write_enable_flop_next = 1'b0;
        pre_ok = os_run[6] && !stop && rw_reg; // see RQ20
        rd_ok = os_run[6] && !stop && !rw_reg && match_reg; // see RQ23
        pre_cnt_next = pre_cnt_reg;
        if ((pre_ok || rd_ok) && pre_cnt_reg == '0 && !den_reg && !eop_reg && !sync_reg)
            pre_cnt_next = `DSK_CNT_W'(T_PRE - T_MATCH); // see RQ19
        else if (tick && pre_cnt_reg != '0)
            pre_cnt_next = pre_cnt_reg - `DSK_CNT_W'(1);
        ring_next = ring_reg;
        if (tick && write_enable_flop_reg)
            ring_next = {ring_reg[2:0], ring_reg[3]}; // see RQ16
        if (!write_enable_flop_reg)
            ring_next = 4'(dsk_pkg::DSK_WS_10);
        eop_next = eop_reg;
        sync_next = sync_reg;
        den_next = den_reg;
        if (pre_end && rw_reg)
            eop_next = 1'b1;
        if (tick && ring_reg == 4'(dsk_pkg::DSK_WS_10))
        begin
            sync_next = eop_reg;
            if (sync_reg && !eop_reg)
                den_next = 1'b1;
            if (eop_reg)
                eop_next = 1'b0;
        end
        if (!write_enable_flop_reg)
        begin
            eop_next = 1'b0;
            sync_next = 1'b0;
            den_next = 1'b0;
        end
        // Clock slot always writes a one; data slot writes sync bit or data; see RQ17.
        out_next = 1'b0;
        if (write_enable_flop_reg && ring_reg == 4'(dsk_pkg::DSK_WS_10))
            out_next = 1'b1;
        if (write_enable_flop_reg && ring_reg == 4'(dsk_pkg::DSK_WS_01))
            out_next = sync_reg || (den_reg && wdata);
        rgate_next = rgate_reg;
        if (pre_end && !rw_reg)
            rgate_next = 1'b1; // see RQ23
        if (!match_reg)
            rgate_next = 1'b0;
        done_next = stop && match_reg && !write_enable_flop_reg; // see RQ24
        att_hit_next = sel_att;
        os_start = '0;
        os_start[0] = seek_cmd && !cyl_n && cyl_d_reg; // see RQ2
        os_start[1] = os_end[0];
        os_start[2] = !tas_reg && tas_next; // see RQ7
        os_start[3] = os_end[2];
        os_start[4] = smark && !smark_d_reg; // see RQ13
        os_start[5] = (!match_reg && match_next) || (os_end[4] && write_enable_flop_reg); // see RQ15 RQ22
        os_start[6] = os_end[5];
    end
    assign pre_end = tick && (pre_cnt_reg == `DSK_CNT_W'(1));

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            // Reset clears the control flops but sets cyl_d_reg and loads ring_reg with state 10; see RQ25.
            div_reg <= 5'h00;
            tas_reg <= 1'b0;
            rw_reg <= 1'b0;
            match_reg <= 1'b0;
            write_enable_flop_reg <= 1'b0;
            rgate_reg <= 1'b0;
            done_reg <= 1'b0;
            cyl_d_reg <= 1'b1;
            smark_d_reg <= 1'b0;
            att_hit_reg <= 1'b0;
            track_reg <= 8'h00;
            home_reg <= 1'b0;
            ring_reg <= 4'(dsk_pkg::DSK_WS_10);
            pre_cnt_reg <= '0;
            eop_reg <= 1'b0;
            sync_reg <= 1'b0;
            den_reg <= 1'b0;
            out_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            tas_reg <= tas_next;
            rw_reg <= rw_next;
            match_reg <= match_next;
            write_enable_flop_reg <= write_enable_flop_next;
            rgate_reg <= rgate_next;
            done_reg <= done_next;
            cyl_d_reg <= cyl_n;
            smark_d_reg <= smark;
            att_hit_reg <= att_hit_next;
            track_reg <= track_next;
            home_reg <= home_next;
            ring_reg <= ring_next;
            pre_cnt_reg <= pre_cnt_next;
            eop_reg <= eop_next;
            sync_reg <= sync_next;
            den_reg <= den_next;
            out_reg <= out_next;
        end
    end

    assign o_track_line = track_reg; // see RQ6
    assign o_home_heads = home_reg;
    assign o_track_strobe_n = !tas_reg; // see RQ5
    assign o_unit_select = sel_dec;
    assign o_controller_attention = att2_reg; // see RQ9
    assign o_seek_complete = att_hit_reg; // see RQ10
    assign o_checkword_clear = match_reg; // see RQ14
    assign o_post_match_delay = os_run[6]; // see RQ15
    assign o_write_gate_n = !write_enable_flop_reg; // see RQ18
    assign o_erase_gate_n = !write_enable_flop_reg; // see RQ21
    assign o_read_gate = rgate_reg;
    assign o_write_clock_data = out_reg;
    assign o_clock_bit_slot = write_enable_flop_reg && ring_reg == 4'(dsk_pkg::DSK_WS_10);
    assign o_data_bit_slot = write_enable_flop_reg && ring_reg == 4'(dsk_pkg::DSK_WS_01);
    assign o_done = done_reg;
endmodule
`default_nettype wire

// ===== dsk_seek_write_properties.sv
// Port-timing checker for the disk seek and write start block.
// Assumes it is bound onto dsk_seek_write and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dsk_props #(
    parameter int CLR_PULSE_TICKS = 2
)(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_command_code_bit_b,
    input wire logic i_unit_code_low,
    input wire logic i_unit_code_high,
    input wire logic i_addr_ack_n,
    input wire logic [3:0] i_drive_attention,
    input wire logic o_track_strobe_n,
    input wire logic [3:0] o_unit_select,
    input wire logic [3:0] o_controller_attention,
    input wire logic o_write_gate_n,
    input wire logic o_erase_gate_n,
    input wire logic o_clock_bit_slot,
    input wire logic o_data_bit_slot,
    input wire logic o_checkword_clear,
    input wire logic o_done
);
    // Two spare ticks allow for input sync, so a stuck timer still shows.
    localparam int MAX_LOW = (462 + CLR_PULSE_TICKS) * 17;
    int low_reg;
    int low_next;
    always_comb low_next = o_track_strobe_n ? 0 : low_reg + 1;
    always_ff @(posedge i_sys_clk) low_reg <= i_reset ? 0 : low_next;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    a_unit_decode: assert property (
        $stable({i_unit_code_high, i_unit_code_low})[*3]
        |-> o_unit_select == 4'h1 << {i_unit_code_high, i_unit_code_low})
        else $error("unit select wrong");
    a_atten_pass: assert property (
        $stable(i_drive_attention)[*3] |-> o_controller_attention == i_drive_attention)
        else $error("attention not passed");
    a_ack_clears: assert property (
        (!i_addr_ack_n)[*5] |-> o_track_strobe_n) else $error("ack did not clear strobe");
    a_strobe_bound: assert property (
        low_reg <= MAX_LOW) else $error("strobe not timed out");
    a_seek_only: assert property (
        $fell(o_track_strobe_n) |-> i_command_code_bit_b) else $error("strobe without seek");
    a_gates_paired: assert property (
        o_write_gate_n == o_erase_gate_n) else $error("write and erase gates differ");
    a_slot_order: assert property (
        $rose(o_clock_bit_slot) |-> !o_data_bit_slot
        ##[33:35] ($rose(o_data_bit_slot) || o_write_gate_n)) else $error("slot order wrong");
    a_slot_width: assert property (
        $rose(o_data_bit_slot) |-> ##16 (o_data_bit_slot || o_write_gate_n)
        ##1 !o_data_bit_slot) else $error("slot width wrong");
    a_gate_match: assert property (
        $fell(o_write_gate_n) |-> o_checkword_clear) else $error("gate without match");
    a_done_gates: assert property (
        $rose(o_done) |-> o_write_gate_n) else $error("done with gate on");
    c_seek: cover property ($fell(o_track_strobe_n));
    c_write: cover property ($fell(o_write_gate_n));
    c_done: cover property ($rose(o_done));
endmodule
bind dsk_seek_write dsk_props #(.CLR_PULSE_TICKS(CLR_PULSE_TICKS)) u_props (
    .i_sys_clk, .i_reset, .i_command_code_bit_b, .i_unit_code_low, .i_unit_code_high,
    .i_addr_ack_n, .i_drive_attention, .o_track_strobe_n, .o_unit_select,
    .o_controller_attention, .o_write_gate_n, .o_erase_gate_n, .o_clock_bit_slot,
    .o_data_bit_slot, .o_checkword_clear, .o_done
);
`default_nettype wire

// ===== dsk_seek_write_tb.sv
// Self-checking bench for the disk seek and write start block.
// Assumes the checker is bound in; the drive model answers a seek only when ack_on is set.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
    begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module dsk_seek_write_tb;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic cmd_a = 1'b0;
    logic cmd_b = 1'b0;
    logic cyl_n = 1'b1;
    logic [7:0] bus = 8'h00;
    logic u_lo = 1'b0;
    logic u_hi = 1'b0;
    logic xfer = 1'b0;
    logic stop = 1'b0;
    logic ack_on = 1'b0;
    logic [3:0] req = 4'h0;
    wire logic ack_n;
    wire logic mark;
    wire logic [3:0] sector;
    wire logic [3:0] att;
    logic [7:0] track;
    logic home;
    logic strobe_n;
    logic [3:0] usel;
    logic [3:0] catt;
    logic sc;
    logic wg_n;
    logic rg;
    logic wcd;
    logic cs;
    logic done;
    int n_errors = 0;
    int checked = 0;
    int t_low = 0;
    int t_mark = 0;
    int m_cnt = 0;
    int cs_n = 0;
    int wr_n = 0;
    logic [15:0] exp_q[$];
    logic [8:0] p = 9'h000;
    wire logic [8:0] v = {done, rg, wg_n, sc, strobe_n, mark, xfer, cs, wcd};
    dsk_seek_write #(.CLR_PULSE_TICKS(2)) dut (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_command_code_bit_a(cmd_a),
        .i_command_code_bit_b(cmd_b), .i_cylinder_load_request_n(cyl_n), .i_bus(bus),
        .i_unit_code_low(u_lo), .i_unit_code_high(u_hi), .i_addr_ack_n(ack_n),
        .i_drive_attention(att), .i_transfer_control_strobe(xfer), .i_req_sector(req),
        .i_drive_sector_address(sector), .i_sector_mark(mark),
        .i_transfer_stop_flag(stop), .i_write_data(1'b0), .o_track_line(track),
        .o_home_heads(home), .o_track_strobe_n(strobe_n), .o_unit_select(usel),
        .o_controller_attention(catt), .o_seek_complete(sc), .o_checkword_clear(),
        .o_post_match_delay(), .o_write_gate_n(wg_n), .o_erase_gate_n(), .o_read_gate(rg),
        .o_write_clock_data(wcd), .o_clock_bit_slot(cs), .o_data_bit_slot(), .o_done(done)
    );
    dsk_drive_model drive (
        .i_sys_clk(i_sys_clk), .i_strobe_n(strobe_n), .i_select(usel), .i_ack_on(ack_on),
        .o_ack_n(ack_n), .o_attention(att), .o_sector_mark(mark), .o_sector(sector)
    );
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic take(input logic [15:0] act);
        logic [15:0] e;
        e = 16'hFFFF;
        if (exp_q.size() != 0)
            e = exp_q.pop_front();
        `CHK(act, e)
    endtask
    task automatic drain(input int left);
        int k;
        for (k = 0; k < 40000 && exp_q.size() > left; k++)
            @(negedge i_sys_clk);
        `CHK(exp_q.size() <= left, 1'b1)
    endtask
    function automatic logic near(input int t);
        near = t > 6950 && t < 7250;
    endfunction
    // Every outcome is an event at the ports, checked in the order it was noted.
    always @(posedge i_sys_clk)
    begin
        logic [8:0] r;
        logic [8:0] f;
        r = v & ~p;
        f = ~v & p;
        p <= v;
        t_low <= v[4] ? 0 : t_low + 1;
        t_mark <= r[3] ? 0 : t_mark + 1;
        m_cnt <= r[2] ? 0 : m_cnt + int'(r[3]);
        cs_n <= f[6] ? int'(r[1]) : cs_n + int'(r[1]);
        wr_n <= f[6] ? int'(r[0]) : wr_n + int'(r[0]);
        if (!i_reset)
        begin
            if (f[4]) take({4'h1, 3'h0, home, track});
            if (r[4]) take({4'h6, 11'h0, t_low > 7000});
            if (r[5]) take({4'h2, 4'h0, catt, usel});
            if (f[6]) take({4'h3, m_cnt[3:0], 7'h0, near(t_mark)});
            if (r[6]) take({4'h7, 11'h0, near(t_mark)});
            if (r[7]) take({4'h4, m_cnt[3:0], 7'h0, t_mark > 12650 && t_mark < 13150});
            if (r[8]) take({4'h5, 4'h0, 8'(wr_n - cs_n)});
        end
    end
    task automatic seek(input logic [1:0] cmd, input logic ack);
        logic [7:0] a;
        logic [1:0] u;
        a = 8'($urandom);
        u = 2'($urandom);
        @(negedge i_sys_clk);
        {cmd_b, cmd_a} = cmd;
        bus = a;
        {u_hi, u_lo} = u;
        ack_on = ack;
        exp_q.push_back({4'h1, 3'h0, cmd == 2'h3, a});
        exp_q.push_back({4'h6, 11'h0, !ack});
        if (ack)
            exp_q.push_back({4'h2, 4'h0, 4'h1 << u, 4'h1 << u});
        repeat (4) @(negedge i_sys_clk);
        cyl_n = 1'b0;
        repeat (20) @(negedge i_sys_clk);
        cyl_n = 1'b1;
        drain(0);
    endtask
    task automatic transfer(input logic wr, input logic [3:0] ahead);
        @(negedge mark);
        @(negedge i_sys_clk);
        req = sector + ahead;
        {cmd_b, cmd_a} = {1'b0, wr};
        xfer = 1'b1;
        if (wr)
        begin
            exp_q.push_back({4'h3, ahead, 8'h01});
            exp_q.push_back({4'h7, 12'h001});
            exp_q.push_back({4'h5, 12'h001});
            drain(2);
            stop = 1'b1;
            drain(0);
        end
        else
        begin
            exp_q.push_back({4'h4, ahead, 8'h01});
            drain(0);
        end
        xfer = 1'b0;
        stop = 1'b0;
    endtask
    initial
    begin
        forever
            #5 i_sys_clk = ~i_sys_clk;
    end
    initial
    begin
        repeat (95000) @(posedge i_sys_clk);
        n_errors++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(24560));
        repeat (8) @(negedge i_sys_clk);
        i_reset = 1'b0;
        repeat (4) @(negedge i_sys_clk);
        seek(2'h2, 1'b1);
        seek(2'h3, 1'b1);
        seek(2'h2, 1'b0);
        // A load request under a read code must start nothing.
        {cmd_b, cmd_a} = 2'h0;
        cyl_n = 1'b0;
        repeat (600) @(negedge i_sys_clk);
        cyl_n = 1'b1;
        transfer(1'b1, 4'h1);
        transfer(1'b0, 4'h1);
        give_verdict();
    end
endmodule
`default_nettype wire
